//--- shared/lkos_pkg.sv
// Constants, types and helpers of the lock-in output scaling datapath.
// Assumes a single 25 MHz clock and 16-bit signed codes where full scale
// (10 V, 100 %, 180 degrees) is FS_CODE.
package lkos_pkg;

  localparam int CLK_HZ          = 32'h017D_7840;
  localparam int DISP_RATE_HZ    = 32'h0000_0200;
  localparam int DISP_PERIOD_CYC = CLK_HZ / DISP_RATE_HZ;

  localparam int VW        = 24;
  localparam int NW        = 34;
  localparam int RW        = 20;
  localparam int DIV_STEPS = 14;

  localparam logic signed [15:0] FS_CODE = 16'sh4000;
  // Offsets are held in steps of 0.1 % of full scale
  localparam logic signed [15:0] OFF_MAX = 16'sh041A;
  // 16.384 codes per 0.1 %, approximated as 0x4189 / 1024
  localparam logic [14:0]        OFF_MUL = 15'h4189;
  localparam int                 OFF_SHR = 10;

  localparam logic [1:0] EXP_X1   = 2'h0;
  localparam logic [1:0] EXP_X10  = 2'h1;
  localparam logic [1:0] EXP_X100 = 2'h2;

  localparam logic [7:0] REG_X_OFF  = 8'h00;
  localparam logic [7:0] REG_Y_OFF  = 8'h04;
  localparam logic [7:0] REG_R_OFF  = 8'h08;
  localparam logic [7:0] REG_EXPAND = 8'h0C;
  localparam logic [7:0] REG_DCFG   = 8'h10;
  localparam logic [7:0] REG_GAIN   = 8'h14;
  localparam logic [7:0] REG_IND    = 8'h18;
  localparam logic [7:0] REG_DISP1  = 8'h1C;
  localparam logic [7:0] REG_DISP2  = 8'h20;

  localparam int EXP_X_LSB = 0;
  localparam int EXP_Y_LSB = 2;
  localparam int EXP_R_LSB = 4;
  localparam int CFG1_LSB  = 0;
  localparam int CFG2_LSB  = 8;

  localparam logic [11:0] RST_OFF   = 12'h000;
  localparam logic [5:0]  RST_EXP   = 6'h00;
  localparam logic [5:0]  RST_CFG   = 6'h00;
  localparam logic [2:0]  RST_SHIFT = 3'h0;

  // Channel 1: main X, mag R; channel 2: main Y, mag phase
  typedef enum logic [2:0] {
    Q_MAIN, Q_MAG, Q_NOISE, Q_AUXA, Q_AUXB
  } lkos_qty_t;

  typedef enum logic [1:0] {DIV_NONE, DIV_AUXA, DIV_AUXB} lkos_div_t;

  typedef enum logic [1:0] {S_IDLE, S_DIV, S_DONE} lkos_fsm_t;

  typedef struct packed {
    logic      follow;
    lkos_div_t div;
    lkos_qty_t qty;
  } lkos_chcfg_t;

  typedef struct packed {
    logic offs;
    logic expd;
    logic ratio;
  } lkos_ind_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] r;
    logic signed [15:0] theta;
    logic signed [15:0] xn;
    logic signed [15:0] yn;
  } lkos_det_t;

  typedef struct packed {
    logic signed [15:0] a1;
    logic signed [15:0] a2;
    logic signed [15:0] a3;
    logic signed [15:0] a4;
  } lkos_aux_t;

  typedef struct packed {
    logic signed [11:0]   x_off;
    logic signed [11:0]   y_off;
    logic signed [11:0]   r_off;
    logic [5:0]           expd;
    lkos_chcfg_t [1:0]    cfg;
    logic [2:0]           shift;
    logic [31:0]          rdata;
    logic signed [15:0]   rear_x;
    logic signed [15:0]   rear_y;
    logic [1:0][15:0]     front;
    logic [1:0][15:0]     disp;
    lkos_ind_t [1:0]      ind;
    logic [15:0]          tick_cnt;
    lkos_fsm_t            fsm;
    logic [3:0]           step;
    logic [1:0][RW-1:0]   rem;
    logic [1:0][RW-1:0]   dv;
    logic [1:0][13:0]     quo;
    logic [1:0]           neg;
    logic [1:0]           sat;
    logic [1:0]           rat;
    logic [1:0][15:0]     plain;
    logic                 upd;
  } lkos_state_t;

  function automatic logic signed [15:0] sat_fs(
    input logic signed [NW-1:0] v
  );
    logic signed [15:0] r;
    if (v > NW'(FS_CODE)) r = FS_CODE;
    else if (v < -NW'(FS_CODE)) r = -FS_CODE;
    else r = v[15:0];
    return r;
  endfunction

endpackage

//--- rtl/lkos_offexp.sv
// Offset and expand of one quantity: display value, ratio numerator and
// saturated output code. Purely combinational; the caller registers.
`timescale 1ns/10ps
module lkos_offexp
  import lkos_pkg::*;
(
  // Quantity and its settings
  input  wire logic signed [VW-1:0] val_i,
  input  wire logic signed [11:0]   off_i,
  input  wire logic [1:0]           exp_i,
  // Results
  output logic signed [15:0]        disp_o,
  output logic signed [NW-1:0]      num_o,
  output logic signed [15:0]        out_o
);
  logic signed [NW-1:0] off_frac;
  logic signed [NW-1:0] diff;
  logic signed [NW-1:0] mul;

  always_comb begin
    off_frac = (NW'(off_i) * NW'($signed({1'b0, OFF_MUL}))) >>> OFF_SHR;
    diff     = NW'(val_i) - off_frac;
    case (exp_i)
      EXP_X10:  mul = 34'sh0_0000_000A;
      EXP_X100: mul = 34'sh0_0000_0064;
      default:  mul = 34'sh0_0000_0001;
    endcase
    disp_o = sat_fs(diff);
    num_o  = NW'(diff * mul);
    out_o  = sat_fs(num_o);
  end
endmodule

//--- rtl/lkos_scaling.sv
// Output scaling datapath of a lock-in: offset, expand, display selection,
// ratio percentages, indicators and output converter codes.
// Assumes detector and aux samples arrive on ref_clk_i, already filtered.
//
// What this block does
// - Rear X and Y outputs carry filtered detector values with offset, expand.
// - Front outputs show either their display or X / Y like the rear.
// - A front output following its display refreshes at 512 Hz only.
// - Display one shows X, R, X noise, aux 1 or 2, optionally ratioed.
// - Display two shows Y, phase, Y noise, aux 3 or 4, optionally ratioed.
// - Total gain stays full scale over sensitivity; reserve only shifts split.
// - Full scale of plain X, Y or R maps to 10 V everywhere.
// - Phase spans +-180 degrees at 18 degrees per volt.
// - Offsets are percent of full scale, up to +-105, sensitivity independent.
// - Output equals (signal/sens - offset) times expand times 10 V, limited.
// - X, Y offset and expand act on X and Y only; R has its own.
// - Displays subtract the active offset from affected quantities.
// - Offset indicator lights when a nonzero offset affects the display.
// - Expand raises resolution only and never scales plain displayed values.
// - Expand indicator lights when a non-unity expand affects the display.
// - Ratio display percent is expanded numerator over aux volts, max 100.
// - Phase as ratio numerator uses 180 degrees as full scale.
// - Ratio indicator is on while a ratio divisor is selected, from one edge after the setting.
// - Front output following a ratio display gives percent times 10 V.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module lkos_scaling
  import lkos_pkg::*;
#(
  parameter int DISP_PERIOD = DISP_PERIOD_CYC
)(
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // Register port
  input  wire logic [7:0]        addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [31:0]            rdata_o,
  // Detector and aux samples
  input  wire lkos_det_t         det_i,
  input  wire logic              det_valid_i,
  input  wire lkos_aux_t         aux_i,
  // Converter codes
  output logic signed [15:0]     rear_x_o,
  output logic signed [15:0]     rear_y_o,
  output logic signed [15:0]     front1_o,
  output logic signed [15:0]     front2_o,
  // Display values and indicators
  output logic signed [15:0]     disp1_o,
  output logic signed [15:0]     disp2_o,
  output lkos_ind_t              ind1_o,
  output lkos_ind_t              ind2_o,
  output logic                   disp_upd_o
);
  lkos_state_t st_q;
  lkos_state_t st_d;

  logic signed [VW-1:0] xs;
  logic signed [VW-1:0] ys;
  logic signed [VW-1:0] rs;
  logic signed [VW-1:0] xns;
  logic signed [VW-1:0] yns;
  logic signed [15:0]   xd, yd, rd;
  logic signed [15:0]   xo, yo;
  logic signed [NW-1:0] xn, yn, rn;
  logic signed [15:0]   qv [2][5];
  logic signed [NW-1:0] qn [2][5];
  logic                 qo [2][5];
  logic                 qe [2][5];
  logic signed [15:0]   av [2][2];
  logic                 rat_sel1;

  always_comb begin
    xs  = VW'(det_i.x)  <<< st_q.shift;
    ys  = VW'(det_i.y)  <<< st_q.shift;
    rs  = VW'(det_i.r)  <<< st_q.shift;
    xns = VW'(det_i.xn) <<< st_q.shift;
    yns = VW'(det_i.yn) <<< st_q.shift;
  end

  lkos_offexp u_x (
    .val_i  (xs),
    .off_i  (st_q.x_off),
    .exp_i  (st_q.expd[EXP_X_LSB +: 2]),
    .disp_o (xd),
    .num_o  (xn),
    .out_o  (xo)
  );

  lkos_offexp u_y (
    .val_i  (ys),
    .off_i  (st_q.y_off),
    .exp_i  (st_q.expd[EXP_Y_LSB +: 2]),
    .disp_o (yd),
    .num_o  (yn),
    .out_o  (yo)
  );

  lkos_offexp u_r (
    .val_i  (rs),
    .off_i  (st_q.r_off),
    .exp_i  (st_q.expd[EXP_R_LSB +: 2]),
    .disp_o (rd),
    .num_o  (rn),
    .out_o  ()
  );

  always_comb begin
    qv[0] = '{xd, rd, sat_fs(NW'(xns)), aux_i.a1, aux_i.a2};
    qn[0] = '{xn, rn, NW'(xns), NW'(aux_i.a1), NW'(aux_i.a2)};
    qv[1] = '{yd, det_i.theta, sat_fs(NW'(yns)), aux_i.a3, aux_i.a4};
    qn[1] = '{yn, NW'(det_i.theta), NW'(yns), NW'(aux_i.a3),
              NW'(aux_i.a4)};
    qo[0] = '{st_q.x_off != 12'h000, st_q.r_off != 12'h000, 1'b0, 1'b0,
              1'b0};
    qo[1] = '{st_q.y_off != 12'h000, 1'b0, 1'b0, 1'b0, 1'b0};
    qe[0] = '{st_q.expd[EXP_X_LSB +: 2] != EXP_X1,
              st_q.expd[EXP_R_LSB +: 2] != EXP_X1, 1'b0, 1'b0, 1'b0};
    qe[1] = '{st_q.expd[EXP_Y_LSB +: 2] != EXP_X1, 1'b0, 1'b0, 1'b0, 1'b0};
    av[0] = '{aux_i.a1, aux_i.a2};
    av[1] = '{aux_i.a3, aux_i.a4};
  end

  assign rat_sel1 = st_q.cfg[0].div != DIV_NONE;

  always_comb begin
    int                 qi;
    logic               tick;
    logic signed [15:0] a;
    logic signed [NW-1:0] n;
    logic [15:0]        absa;
    logic [NW-1:0]      absn;
    logic [RW-1:0]      dvs;
    logic [RW-1:0]      r2;
    logic [15:0]        res;
    qi   = 0;
    a    = 16'sh0000;
    n    = '0;
    absa = 16'h0000;
    absn = '0;
    dvs  = '0;
    r2   = '0;
    res  = 16'h0000;
    st_d = st_q;
    st_d.upd = 1'b0;
    tick = st_q.tick_cnt == 16'(DISP_PERIOD - 1);
    st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

    // Register writes; offsets are clamped so the range always holds
    if (wr_i) begin
      case (addr_i)
        REG_X_OFF, REG_Y_OFF, REG_R_OFF: begin
          res = wdata_i[15:0];
          if ($signed(res) > OFF_MAX) res = OFF_MAX;
          else if ($signed(res) < -OFF_MAX) res = -OFF_MAX;
          if (addr_i == REG_X_OFF) st_d.x_off = res[11:0];
          else if (addr_i == REG_Y_OFF) st_d.y_off = res[11:0];
          else st_d.r_off = res[11:0];
        end
        REG_EXPAND: st_d.expd = wdata_i[5:0];
        REG_DCFG: begin
          st_d.cfg[0] = wdata_i[CFG1_LSB +: 6];
          st_d.cfg[1] = wdata_i[CFG2_LSB +: 6];
        end
        REG_GAIN: st_d.shift = wdata_i[2:0];
        default: ;
      endcase
    end

    // Read data stand only in the cycle after the strobe
    st_d.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        REG_X_OFF:  st_d.rdata = 32'($signed(st_q.x_off));
        REG_Y_OFF:  st_d.rdata = 32'($signed(st_q.y_off));
        REG_R_OFF:  st_d.rdata = 32'($signed(st_q.r_off));
        REG_EXPAND: st_d.rdata = {26'h0, st_q.expd};
        REG_DCFG:   st_d.rdata = {18'h0, st_q.cfg[1], 2'h0, st_q.cfg[0]};
        REG_GAIN:   st_d.rdata = {29'h0, st_q.shift};
        REG_IND:    st_d.rdata = {26'h0, st_q.ind[1], st_q.ind[0]};
        REG_DISP1:  st_d.rdata = 32'($signed(st_q.disp[0]));
        REG_DISP2:  st_d.rdata = 32'($signed(st_q.disp[1]));
        default:    st_d.rdata = 32'h0000_0000;
      endcase
    end

    if (det_valid_i) begin
      st_d.rear_x = xo;
      st_d.rear_y = yo;
    end

    for (int c = 0; c < 2; c++) begin
      qi = (st_q.cfg[c].qty > Q_AUXB) ? 0 : int'(st_q.cfg[c].qty);
      st_d.ind[c].offs  = qo[c][qi];
      st_d.ind[c].expd  = qe[c][qi];
      st_d.ind[c].ratio = st_q.cfg[c].div != DIV_NONE;
      if (!st_q.cfg[c].follow) begin
        st_d.front[c] = (c == 0) ? st_d.rear_x : st_d.rear_y;
      end
    end

    case (st_q.fsm)
      S_IDLE: begin
        if (tick) begin
          for (int c = 0; c < 2; c++) begin
            qi = (st_q.cfg[c].qty > Q_AUXB) ? 0 : int'(st_q.cfg[c].qty);
            n  = qn[c][qi];
            a  = (st_q.cfg[c].div == DIV_AUXB) ? av[c][1] : av[c][0];
            absn = n[NW-1] ? NW'(-n) : NW'(n);
            absa = a[15] ? 16'(-a) : 16'(a);
            // Ten aux codes per FS code turns aux volts into percent
            dvs  = (RW'(absa) << 3) + (RW'(absa) << 1);
            st_d.plain[c] = qv[c][qi];
            st_d.rat[c]   = st_q.cfg[c].div != DIV_NONE;
            st_d.neg[c]   = n[NW-1] ^ a[15];
            st_d.sat[c]   = (absa == 16'h0000) || (absn >= NW'(dvs));
            st_d.rem[c]   = absn[RW-1:0];
            st_d.dv[c]    = dvs;
            st_d.quo[c]   = 14'h0000;
          end
          st_d.step = 4'h0;
          st_d.fsm  = S_DIV;
        end
      end
      S_DIV: begin
        for (int c = 0; c < 2; c++) begin
          r2 = {st_q.rem[c][RW-2:0], 1'b0};
          if (r2 >= st_q.dv[c]) begin
            st_d.rem[c] = r2 - st_q.dv[c];
            st_d.quo[c] = {st_q.quo[c][12:0], 1'b1};
          end else begin
            st_d.rem[c] = r2;
            st_d.quo[c] = {st_q.quo[c][12:0], 1'b0};
          end
        end
        st_d.step = st_q.step + 4'h1;
        if (st_q.step == 4'(DIV_STEPS - 1)) st_d.fsm = S_DONE;
      end
      S_DONE: begin
        for (int c = 0; c < 2; c++) begin
          if (!st_q.rat[c]) res = st_q.plain[c];
          else if (st_q.sat[c]) res = st_q.neg[c] ? -FS_CODE : FS_CODE;
          else res = st_q.neg[c] ? -{2'b00, st_q.quo[c]}
                                 : {2'b00, st_q.quo[c]};
          st_d.disp[c] = res;
          if (st_q.cfg[c].follow) st_d.front[c] = res;
        end
        st_d.upd = 1'b1;
        st_d.fsm = S_IDLE;
      end
      default: st_d.fsm = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q          <= '0;
      st_q.x_off    <= RST_OFF;
      st_q.y_off    <= RST_OFF;
      st_q.r_off    <= RST_OFF;
      st_q.expd     <= RST_EXP;
      st_q.cfg      <= {RST_CFG, RST_CFG};
      st_q.shift    <= RST_SHIFT;
      st_q.fsm      <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o    = st_q.rdata;
  assign rear_x_o   = st_q.rear_x;
  assign rear_y_o   = st_q.rear_y;
  assign front1_o   = st_q.front[0];
  assign front2_o   = st_q.front[1];
  assign disp1_o    = st_q.disp[0];
  assign disp2_o    = st_q.disp[1];
  assign ind1_o     = st_q.ind[0];
  assign ind2_o     = st_q.ind[1];
  assign disp_upd_o = st_q.upd;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_tick_start;
    st_q.fsm == S_IDLE && st_q.tick_cnt == 16'(DISP_PERIOD - 1);
  endsequence
  sequence s_update;
    ##16 disp_upd_o;
  endsequence

  a_rear_track: assert property (det_valid_i |=> rear_x_o == $past(xo))
    else $error("rear X missed a detector sample");
  a_front_dup: assert property (!st_q.cfg[0].follow |=> front1_o == rear_x_o)
    else $error("front output differs from rear X");
  a_front_hold: assert property (
      st_q.cfg[0].follow && st_q.fsm != S_DONE |=> $stable(front1_o))
    else $error("front output changed between display updates");
  a_update_delay: assert property (s_tick_start |-> s_update)
    else $error("display update not 16 cycles after tick");
  a_rear_limit: assert property (
      rear_x_o <= FS_CODE && rear_x_o >= -FS_CODE)
    else $error("rear X beyond full scale");
  a_disp_limit: assert property (
      disp1_o <= FS_CODE && disp1_o >= -FS_CODE)
    else $error("display one beyond limit");
  a_off_range: assert property (
      $signed(st_q.x_off) <= OFF_MAX && $signed(st_q.x_off) >= -OFF_MAX)
    else $error("X offset beyond range");
  a_ratio_ind: assert property (##1 ind1_o.ratio == $past(rat_sel1))
    else $error("ratio indicator wrong");
  a_off_ind: assert property (
      st_q.cfg[0].qty == Q_MAIN && st_q.x_off != 12'h000 |=> ind1_o.offs)
    else $error("offset indicator dark");
  a_exp_ind: assert property (st_q.cfg[0].qty == Q_MAIN
      && st_q.expd[EXP_X_LSB +: 2] == EXP_X10 |=> ind1_o.expd)
    else $error("expand indicator dark");
endmodule

//--- dv/lkos_conv_model.sv
// Far-side model: front panel capture of display one and its load period.
// Assumes codes settle on the edge that sees disp_upd_i high.
`timescale 1ns/10ps
module lkos_conv_model
  import lkos_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               reset_i,
  // Display side of the block
  input  wire logic               disp_upd_i,
  input  wire logic signed [15:0] disp1_i,
  // Captured view
  output logic signed [15:0]      shown1_o,
  output logic [15:0]             period_o
);
  logic [15:0] cnt_q;

  // Display latches at each load; period counts edges between loads
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q    <= 16'h0000;
      period_o <= 16'h0000;
      shown1_o <= 16'sh0000;
    end else if (disp_upd_i) begin
      cnt_q    <= 16'h0001;
      period_o <= cnt_q;
      shown1_o <= disp1_i;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule

//--- dv/lockin_output_scaling_offset_expand_tb_top.sv
// Self-checking bench of the output scaling datapath.
// Assumes the register port and detector strobe described by the designer.
`timescale 1ns/10ps
module lockin_output_scaling_offset_expand_tb_top;
  import lkos_pkg::*;
  // Short display period keeps the run brief
  localparam int PER = 40;
  logic               ref_clk_i, reset_i, wr_i, rd_i, det_valid_i;
  logic [7:0]         addr_i;
  logic [31:0]        wdata_i, rdata_o, rv;
  lkos_det_t          det_i;
  lkos_aux_t          aux_i;
  logic signed [15:0] rear_x_o, rear_y_o, front1_o, front2_o;
  logic signed [15:0] disp1_o, disp2_o, shown1;
  lkos_ind_t          ind1_o, ind2_o;
  logic               disp_upd_o;
  logic [15:0]        period;
  int                 miscompares, n_checks, cyc;

  lkos_scaling #(.DISP_PERIOD(PER)) dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .det_i(det_i), .det_valid_i(det_valid_i), .aux_i(aux_i),
    .rear_x_o(rear_x_o), .rear_y_o(rear_y_o), .front1_o(front1_o),
    .front2_o(front2_o), .disp1_o(disp1_o), .disp2_o(disp2_o),
    .ind1_o(ind1_o), .ind2_o(ind2_o), .disp_upd_o(disp_upd_o));

  lkos_conv_model conv (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .disp_upd_i(disp_upd_o),
    .disp1_i(disp1_o), .shown1_o(shown1), .period_o(period));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk16(input string nm, input logic signed [15:0] e,
                       input logic signed [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected 0x%0h seen 0x%0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge ref_clk_i);
  endtask

  task automatic det(input logic signed [15:0] x, input logic signed [15:0] y);
    det_i.x     <= x;
    det_i.y     <= y;
    det_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    det_valid_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  // Two loads are awaited so the second surely saw the new settings
  task automatic upd2();
    int k;
    for (int i = 0; i < 2; i++) begin
      k = 0;
      @(posedge ref_clk_i);
      #1;
      while (disp_upd_o !== 1'b1 && k < 200) begin
        @(posedge ref_clk_i);
        #1;
        k++;
      end
      if (k >= 200) miscompares++;
    end
    @(posedge ref_clk_i);
  endtask

  task automatic tdone(input string n);
    $display("Test %s done, mismatches so far %0d", n, miscompares);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00;
    wdata_i = 32'h0; det_i = '0; det_valid_i = 1'b0; aux_i = '0;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4), rv);
      chk32("reg reset", 32'h0, rv);
    end
    rd(8'hFC, rv);
    chk32("unmapped", 32'h0, rv);
    tdone("reset");
    det_i.r <= 16'sh03E8;
    det(16'sh2000, -16'sh1000);
    chk16("rear_x", 16'sh2000, rear_x_o);
    chk16("rear_y", -16'sh1000, rear_y_o);
    chk16("front1", 16'sh2000, front1_o);
    chk16("front2", -16'sh1000, front2_o);
    upd2();
    chk16("disp1", 16'sh2000, disp1_o);
    chk32("ind1", 32'h0, 32'(ind1_o));
    tdone("plain");
    wr(REG_X_OFF, 32'h1F4);
    wr(REG_EXPAND, 32'h1);
    det(16'sh2328, 16'sh0000);
    chk16("rear_x off x10", 16'sh1F9A, rear_x_o);
    upd2();
    chk16("disp1 off", 16'sh0329, disp1_o);
    rd(REG_IND, rv);
    chk32("ind reg", 32'h6, rv);
    rd(REG_DISP1, rv);
    chk32("disp1 reg", 32'h329, rv);
    wr(REG_X_OFF, 32'h44C);
    rd(REG_X_OFF, rv);
    chk32("x off clamp", 32'h41A, rv);
    det(16'sh2328, 16'sh0000);
    chk16("rear_x neg sat", -16'sh4000, rear_x_o);
    wr(REG_X_OFF, 32'h0);
    wr(REG_EXPAND, 32'hA);
    det(16'sh3E80, -16'sh3E80);
    chk16("rear_x sat", 16'sh4000, rear_x_o);
    chk16("rear_y sat", -16'sh4000, rear_y_o);
    tdone("offset expand");
    wr(REG_EXPAND, 32'h0);
    wr(REG_X_OFF, 32'h1F4);
    wr(REG_R_OFF, 32'hFA);
    wr(REG_DCFG, 32'h1);
    det_i.r <= 16'sh2710;
    det(16'sh2328, 16'sh0000);
    chk16("rear_x x off", 16'sh0329, rear_x_o);
    upd2();
    chk16("disp1 r", 16'sh1711, disp1_o);
    chk32("ind1 r", 32'h4, 32'(ind1_o));
    tdone("r offset");
    wr(REG_X_OFF, 32'h0);
    wr(REG_R_OFF, 32'h0);
    det_i <= '{16'sh0064, -16'sh0064, 16'sh00C8, -16'sh00C8,
               16'sh012C, -16'sh012C};
    aux_i <= '{16'sh0190, 16'sh01F4, -16'sh0190, -16'sh01F4};
    for (int q = 0; q < 5; q++) begin
      wr(REG_DCFG, 32'(q) | (32'(q) << 8));
      upd2();
      chk16("disp1 sel", 16'(100 * (q + 1)), disp1_o);
      chk16("disp2 sel", -16'(100 * (q + 1)), disp2_o);
    end
    tdone("selection");
    wr(REG_DCFG, 32'h20);
    det(16'sh07D0, 16'sh0000);
    upd2();
    chk16("front1 disp", 16'sh07D0, front1_o);
    det(16'sh0FA0, 16'sh0000);
    chk16("front1 held", 16'sh07D0, front1_o);
    upd2();
    chk16("front1 new", 16'sh0FA0, front1_o);
    chk16("period", 16'(PER), period);
    chk16("shown1", 16'sh0FA0, shown1);
    tdone("follow");
    aux_i.a1 <= 16'sh2000;
    aux_i.a3 <= 16'sh2000;
    det_i.theta <= 16'sh2000;
    wr(REG_DCFG, 32'h928);
    det(16'sh2000, 16'sh0000);
    upd2();
    chk16("ratio1", 16'sh0666, disp1_o);
    chk16("front1 ratio", 16'sh0666, front1_o);
    chk16("ratio phase", 16'sh0666, disp2_o);
    chk32("ind ratio", 32'h9, {26'h0, ind2_o, ind1_o});
    aux_i.a1 <= 16'sh0000;
    aux_i.a3 <= -16'sh2000;
    upd2();
    chk16("ratio zero aux", 16'sh4000, disp1_o);
    chk16("ratio neg aux", -16'sh0666, disp2_o);
    // Second divisor of each display, and a saturated negative ratio
    aux_i.a2 <= 16'sh4000;
    aux_i.a4 <= -16'sh0100;
    wr(REG_DCFG, 32'h1110);
    upd2();
    chk16("ratio aux2", 16'sh0333, disp1_o);
    chk16("ratio neg sat", -16'sh4000, disp2_o);
    wr(REG_DCFG, 32'h0);
    // Indicators follow the written settings one edge later
    @(posedge ref_clk_i);
    chk32("ind off", 32'h0, {26'h0, ind2_o, ind1_o});
    tdone("ratio");
    wr(REG_GAIN, 32'h1);
    det(16'sh03E8, -16'sh03E8);
    chk16("rear_x gain", 16'sh07D0, rear_x_o);
    chk16("rear_y gain", -16'sh07D0, rear_y_o);
    tdone("gain");
    print_verdict();
  end
endmodule
